/* src/float_mul_add_datapath.sv */
// floating-point multiply, add, subtract and format conversion datapath
`default_nettype none

// Functional notes
// - format conversion built into every operation
// - narrow zero widens to wider zero
// - short to single: sign-extend exponent, pad fraction
// - short to extended: fixed bit placement, low zeros
// - single to extended keeps exponent, pads fraction
// - extended to single truncates fraction, no rounding
// - multiply sources forced to single precision
// - product extended precision, one cycle
// - 25-bit mantissas give 50-bit product, exponents add
// - zero product mantissa forces exponent minus 128
// - product normalized by right shift 0..2
// - overflow checked after add and normalize
// - overflow saturates toward sign of result
// - underflow replaced by extended zero
// - multiply by zero gives exact zero
// - adder takes larger exponent
// - smaller operand right-aligned, signed add
// - subtract negates and reuses add path
// - zero sum gets most negative exponent
// - sum overflow: shift right one, exponent plus one
// - else left-normalize by redundant sign count
// - short, single, extended field widths
// - extended zero is exponent minus 128
module float_mul_add_datapath
  import fpu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // operation request
  input wire logic op_valid_i,
  input wire op_e op_sel_i,
  input wire operand_s opnd_a_i,
  input wire operand_s opnd_b_i,
  // result
  output logic res_valid_o,
  output ext_fp_s result_o,
  output sgl_fp_s result_sgl_o,
  output logic ovf_o,
  output logic unf_o
);

  // ---------------------------------------------------------------
  // format conversion functions
  // ---------------------------------------------------------------
  function automatic logic [SGL_EXP_W-1:0] sht_exp_wide(input logic [SHT_EXP_W-1:0] e);
    logic [SGL_EXP_W-1:0] w;
    w = {{(SGL_EXP_W - SHT_EXP_W){e[SHT_EXP_W-1]}}, e};
    if (e == SHT_EXP_ZERO) begin
      w = EXP_ZERO;
    end
    return w;
  endfunction : sht_exp_wide

  function automatic sgl_fp_s sht_to_sgl(input short_fp_s s);
    sgl_fp_s g;
    g.exp = sht_exp_wide(s.exp);
    g.sgn = s.sgn;
    g.frac = {s.frac, {(SGL_FRC_W - SHT_FRC_W){1'b0}}};
    if (s.exp == SHT_EXP_ZERO) begin
      g = SGL_ZERO;
    end
    return g;
  endfunction : sht_to_sgl

  function automatic ext_fp_s sht_to_ext(input short_fp_s s);
    ext_fp_s x;
    x.exp = sht_exp_wide(s.exp);
    x.sgn = s.sgn;
    x.frac = {s.frac, {(EXT_FRC_W - SHT_FRC_W){1'b0}}};
    if (s.exp == SHT_EXP_ZERO) begin
      x = EXT_ZERO;
    end
    return x;
  endfunction : sht_to_ext

  function automatic ext_fp_s sgl_to_ext(input sgl_fp_s g);
    ext_fp_s x;
    x.exp = g.exp;
    x.sgn = g.sgn;
    x.frac = {g.frac, {(EXT_FRC_W - SGL_FRC_W){1'b0}}};
    if (g.exp == EXP_ZERO) begin
      x = EXT_ZERO;
    end
    return x;
  endfunction : sgl_to_ext

  function automatic sgl_fp_s ext_to_sgl(input ext_fp_s x);
    sgl_fp_s g;
    g.exp = x.exp;
    g.sgn = x.sgn;
    g.frac = x.frac[EXT_FRC_W-1 -: SGL_FRC_W];
    return g;
  endfunction : ext_to_sgl

  // operand as tagged, widened or narrowed as the operation needs
  function automatic ext_fp_s to_ext(input operand_s op);
    ext_fp_s x;
    x = EXT_ZERO;
    unique case (op.fmt)
      FMT_SHORT: begin
        x = sht_to_ext(short_fp_s'(op.bits[SHT_W-1:0]));
      end
      FMT_SINGLE: begin
        x = sgl_to_ext(sgl_fp_s'(op.bits[SGL_W-1:0]));
      end
      default: begin
        x = ext_fp_s'(op.bits);
      end
    endcase
    return x;
  endfunction : to_ext

  function automatic sgl_fp_s to_sgl(input operand_s op);
    sgl_fp_s g;
    g = SGL_ZERO;
    unique case (op.fmt)
      FMT_SHORT: begin
        g = sht_to_sgl(short_fp_s'(op.bits[SHT_W-1:0]));
      end
      FMT_SINGLE: begin
        g = sgl_fp_s'(op.bits[SGL_W-1:0]);
      end
      default: begin
        g = ext_to_sgl(ext_fp_s'(op.bits));
      end
    endcase
    return g;
  endfunction : to_sgl

  // ---------------------------------------------------------------
  // exponent helpers and result packing
  // ---------------------------------------------------------------
  function automatic logic signed [XEXP_W-1:0] xexp(input logic [EXT_EXP_W-1:0] e);
    return $signed({{(XEXP_W - EXT_EXP_W){e[EXT_EXP_W-1]}}, e});
  endfunction : xexp

  // the wide exponent carries both the raw sum and the shift, so one check covers both
  function automatic result_s pack_result(
    input logic zero,
    input logic signed [XEXP_W-1:0] e,
    input logic sgn,
    input logic [EXT_FRC_W-1:0] frac
  );
    result_s r;
    r.ovf = 1'b0;
    r.unf = 1'b0;
    r.val = '{exp: e[EXT_EXP_W-1:0], sgn: sgn, frac: frac};
    if (zero) begin
      r.val = EXT_ZERO;
    end else if (e > XEXP_MAX) begin
      r.ovf = 1'b1;
      r.val = sgn ? EXT_NEG_MAX : EXT_POS_MAX;
    end else if (e < XEXP_MIN) begin
      r.unf = 1'b1;
      r.val = EXT_ZERO;
    end
    return r;
  endfunction : pack_result

  // ---------------------------------------------------------------
  // multiplier
  // ---------------------------------------------------------------
  wire sgl_fp_s mul_a = to_sgl(opnd_a_i);
  wire sgl_fp_s mul_b = to_sgl(opnd_b_i);
  wire logic signed [MUL_IN_W-1:0] mul_man_a = $signed({mul_a.sgn, ~mul_a.sgn, mul_a.frac});
  wire logic signed [MUL_IN_W-1:0] mul_man_b = $signed({mul_b.sgn, ~mul_b.sgn, mul_b.frac});
  wire logic signed [PROD_W-1:0] prod = mul_man_a * mul_man_b;

  // sources are taken as normalized: other inputs may need more than the 0..2 shift
  // normalized product has its sign at PROD_W-3 and its implied bit below it
  wire logic prod_sh2 = prod[PROD_W-1] != prod[PROD_W-2];
  wire logic prod_sh1 = prod[PROD_W-2] != prod[PROD_W-3];
  wire logic [1:0] mul_sh = prod_sh2 ? 2'h2 : (prod_sh1 ? 2'h1 : 2'h0);
  wire logic signed [PROD_W-1:0] prod_n = prod >>> mul_sh;
  wire logic mul_sgn = prod_n[PROD_W-3];
  wire logic [EXT_FRC_W-1:0] mul_frac = prod_n[PROD_W-5 -: EXT_FRC_W];

  // exponent sum then normalization adjust, checked together after both
  wire logic signed [XEXP_W-1:0] mul_xexp =
    xexp(mul_a.exp) + xexp(mul_b.exp) + $signed(XEXP_W'(mul_sh));

  wire logic mul_src_zero = (mul_a.exp == EXP_ZERO) || (mul_b.exp == EXP_ZERO);
  wire logic prod_zero = prod == '0;
  wire result_s mul_res = pack_result(mul_src_zero || prod_zero, mul_xexp, mul_sgn, mul_frac);

  // ---------------------------------------------------------------
  // adder and subtractor
  // ---------------------------------------------------------------
  // zero operands contribute a zero mantissa whatever the other exponent is
  function automatic logic signed [SUM_W-1:0] ext_man(input ext_fp_s x);
    logic signed [SUM_W-1:0] m;
    m = $signed({{(SUM_W - EXT_FRC_W - 2){x.sgn}}, x.sgn, ~x.sgn, x.frac});
    if (x.exp == EXP_ZERO) begin
      m = '0;
    end
    return m;
  endfunction : ext_man

  wire ext_fp_s add_a = to_ext(opnd_a_i);
  wire ext_fp_s add_b = to_ext(opnd_b_i);
  wire logic signed [XEXP_W-1:0] add_xa = xexp(add_a.exp);
  wire logic signed [XEXP_W-1:0] add_xb = xexp(add_b.exp);
  wire logic a_ge_b = add_xa >= add_xb;
  wire logic signed [XEXP_W-1:0] big_xexp = a_ge_b ? add_xa : add_xb;
  wire logic [XEXP_W-1:0] exp_diff = a_ge_b ? add_xa - add_xb : add_xb - add_xa;

  wire logic signed [SUM_W-1:0] man_a = ext_man(add_a);
  wire logic signed [SUM_W-1:0] man_b_raw = ext_man(add_b);
  // no overflow in the negation: the guard bits hold the magnitude two
  wire logic signed [SUM_W-1:0] man_b = (op_sel_i == OP_SUB) ? -man_b_raw : man_b_raw;

  wire logic signed [SUM_W-1:0] man_big = a_ge_b ? man_a : man_b;
  wire logic signed [SUM_W-1:0] man_small = a_ge_b ? man_b : man_a;
  // bits shifted out of the smaller operand are lost, never rounded
  wire logic signed [SUM_W-1:0] man_align = man_small >>> exp_diff;
  wire logic signed [SUM_W-1:0] sum = man_big + man_align;

  wire logic sum_zero = sum == '0;
  wire logic sum_ovf = sum[SUM_W-2] != sum[SUM_W-3];

  logic [CNT_W-1:0] lsc_n;

  lead_sign_count u_lsc (
    .value_i(sum[NRM_W-1:0]),
    .count_o(lsc_n)
  );

  // right shift drops one low bit; nothing is rounded here
  wire logic signed [SUM_W-1:0] sum_r = sum >>> 1;
  wire logic signed [SUM_W-1:0] sum_l = sum <<< lsc_n;
  wire logic signed [SUM_W-1:0] sum_n = sum_ovf ? sum_r : sum_l;
  wire logic add_sgn = sum_n[NRM_W-1];
  wire logic [EXT_FRC_W-1:0] add_frac = sum_n[EXT_FRC_W-1:0];

  wire logic signed [XEXP_W-1:0] add_adj =
    sum_ovf ? $signed(XEXP_W'(1'b1)) : -$signed(XEXP_W'(lsc_n));
  wire logic signed [XEXP_W-1:0] add_xexp = big_xexp + add_adj;
  wire result_s add_res = pack_result(sum_zero, add_xexp, add_sgn, add_frac);

  // ---------------------------------------------------------------
  // conversion pass and result select
  // ---------------------------------------------------------------
  wire result_s cvt_res = '{val: to_ext(opnd_a_i), ovf: 1'b0, unf: 1'b0};

  result_s res_sel;

  always_comb begin
    res_sel = add_res;
    unique case (op_sel_i)
      OP_MUL: begin
        res_sel = mul_res;
      end
      OP_CVT: begin
        res_sel = cvt_res;
      end
      OP_ADD, OP_SUB: begin
        res_sel = add_res;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  // whole operation is one combinational pass captured on one edge
  result_s res_q;
  result_s res_d;
  logic valid_q;
  logic valid_d;

  assign res_d = op_valid_i ? res_sel : res_q;
  assign valid_d = op_valid_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      res_q <= '{val: EXT_ZERO, ovf: 1'b0, unf: 1'b0};
      valid_q <= 1'b0;
    end else begin
      res_q <= res_d;
      valid_q <= valid_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign res_valid_o = valid_q;
  assign result_o = res_q.val;
  // the single view truncates; callers that need rounding must do it themselves
  assign result_sgl_o = ext_to_sgl(res_q.val);
  assign ovf_o = res_q.ovf;
  assign unf_o = res_q.unf;

endmodule : float_mul_add_datapath

`default_nettype wire

/* src/fpu_pkg.sv */
// shared formats, widths and constants of the float multiply/add datapath
`default_nettype none

package fpu_pkg;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int SHT_EXP_W = 4;
  localparam int SHT_FRC_W = 11;
  localparam int SGL_EXP_W = 8;
  localparam int SGL_FRC_W = 23;
  localparam int EXT_EXP_W = 8;
  localparam int EXT_FRC_W = 31;
  localparam int SHT_W = SHT_EXP_W + 1 + SHT_FRC_W;
  localparam int SGL_W = SGL_EXP_W + 1 + SGL_FRC_W;
  localparam int EXT_W = EXT_EXP_W + 1 + EXT_FRC_W;

  // ---------------------------------------------------------------
  // datapath widths
  // ---------------------------------------------------------------
  // source mantissa is sign plus fraction; the implied bit makes it one wider
  localparam int MAN_W = SGL_FRC_W + 1;
  localparam int MUL_IN_W = MAN_W + 1;
  localparam int PROD_W = 2 * MUL_IN_W;
  // aligned add mantissa: two guard bits above sign, implied bit, fraction
  localparam int SUM_W = EXT_FRC_W + 4;
  localparam int NRM_W = EXT_FRC_W + 2;
  localparam int CNT_W = 6;
  // wide exponent so that sums and adjustments never wrap before the check
  localparam int XEXP_W = 10;

  // ---------------------------------------------------------------
  // reserved codes and limits
  // ---------------------------------------------------------------
  localparam logic [SHT_EXP_W-1:0] SHT_EXP_ZERO = 4'h8;
  localparam logic [EXT_EXP_W-1:0] EXP_ZERO = 8'h80;
  localparam logic [EXT_EXP_W-1:0] EXP_MAX = 8'h7F;
  localparam logic signed [XEXP_W-1:0] XEXP_MAX = 10'sh07F;
  localparam logic signed [XEXP_W-1:0] XEXP_MIN = 10'sh381;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_SHORT  = 2'h0,
    FMT_SINGLE = 2'h1,
    FMT_EXT    = 2'h2
  } fmt_e;

  typedef enum logic [1:0] {
    OP_MUL = 2'h0,
    OP_ADD = 2'h1,
    OP_SUB = 2'h2,
    OP_CVT = 2'h3
  } op_e;

  typedef struct packed {
    logic [SHT_EXP_W-1:0] exp;
    logic sgn;
    logic [SHT_FRC_W-1:0] frac;
  } short_fp_s;

  typedef struct packed {
    logic [SGL_EXP_W-1:0] exp;
    logic sgn;
    logic [SGL_FRC_W-1:0] frac;
  } sgl_fp_s;

  typedef struct packed {
    logic [EXT_EXP_W-1:0] exp;
    logic sgn;
    logic [EXT_FRC_W-1:0] frac;
  } ext_fp_s;

  typedef struct packed {
    fmt_e fmt;
    logic [EXT_W-1:0] bits;
  } operand_s;

  typedef struct packed {
    ext_fp_s val;
    logic ovf;
    logic unf;
  } result_s;

  localparam sgl_fp_s SGL_ZERO = '{exp: EXP_ZERO, sgn: 1'b0, frac: '0};
  localparam ext_fp_s EXT_ZERO = '{exp: EXP_ZERO, sgn: 1'b0, frac: '0};
  localparam ext_fp_s EXT_POS_MAX = '{exp: EXP_MAX, sgn: 1'b0, frac: '1};
  localparam ext_fp_s EXT_NEG_MAX = '{exp: EXP_MAX, sgn: 1'b1, frac: '0};

endpackage : fpu_pkg

`default_nettype wire

/* src/lead_sign_count.sv */
// counter of redundant sign bits below the top bit of a normalizer input
`default_nettype none

module lead_sign_count
  import fpu_pkg::*;
(
  // value to scan, top bit is the sign
  input wire logic [NRM_W-1:0] value_i,
  // number of following bits equal to the sign
  output logic [CNT_W-1:0] count_o
);

  logic [CNT_W-1:0] cnt;
  logic run;

  // ---------------------------------------------------------------
  // scan from the top down
  // ---------------------------------------------------------------
  always_comb begin
    cnt = '0;
    run = 1'b1;
    for (int i = NRM_W - 2; i >= 0; i--) begin
      if (run && (value_i[i] == value_i[NRM_W-1])) begin
        cnt = cnt + 1'b1;
      end else begin
        run = 1'b0;
      end
    end
  end

  assign count_o = cnt;

endmodule : lead_sign_count

`default_nettype wire

/* sim/fpu_dp_chk.sv */
// assertion checker for the float multiply/add datapath
`default_nettype none

module fpu_dp_chk
  import fpu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // request
  input wire logic op_valid_i,
  input wire op_e op_sel_i,
  input wire operand_s opnd_a_i,
  input wire operand_s opnd_b_i,
  // result
  input wire logic res_valid_o,
  input wire ext_fp_s result_o,
  input wire sgl_fp_s result_sgl_o,
  input wire logic ovf_o,
  input wire logic unf_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // operand decode
  // ----------------------------------------
  wire logic [39:0] a_w = opnd_a_i.bits;
  wire logic a_sht = (opnd_a_i.fmt == FMT_SHORT);
  wire logic a_sgl = (opnd_a_i.fmt == FMT_SINGLE);
  wire logic a_zero = a_sht ? (a_w[15:12] == SHT_EXP_ZERO) :
    a_sgl ? (a_w[31:24] == EXP_ZERO) : (a_w[39:32] == EXP_ZERO);
  wire logic [39:0] sht_ext = {{4{a_w[15]}}, a_w[15:0], 20'h0};
  wire logic [39:0] sgl_ext = {a_w[31:0], 8'h0};

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence take_s(op);
    op_valid_i && op_sel_i == op;
  endsequence

  valid_pulse_a: assert property (op_valid_i |=> res_valid_o)
    else $error("no result valid after a request");
  valid_idle_a: assert property (!op_valid_i |=> !res_valid_o)
    else $error("result valid without a request");
  hold_res_a: assert property (!op_valid_i |=> $stable(result_o) && $stable(ovf_o) && $stable(unf_o))
    else $error("result changed without a request");
  sgl_view_a: assert property (result_sgl_o == {result_o[39:31], result_o.frac[30:8]})
    else $error("single view is not the truncated result");
  zero_form_a: assert property (result_o.exp == EXP_ZERO |-> result_o == EXT_ZERO)
    else $error("zero exponent with nonzero sign or fraction");
  mul_zero_a: assert property (take_s(OP_MUL) ##0 a_zero |=>
    result_o == EXT_ZERO && !ovf_o && !unf_o) else $error("zero operand product not zero");
  ovf_sat_a: assert property (ovf_o |-> !unf_o &&
    result_o == (result_o.sgn ? EXT_NEG_MAX : EXT_POS_MAX)) else $error("overflow not saturated");
  unf_zero_a: assert property (unf_o |-> result_o == EXT_ZERO)
    else $error("underflow result not zero");
  cvt_zero_a: assert property (take_s(OP_CVT) ##0 a_zero |=> result_o == EXT_ZERO)
    else $error("widened zero is not extended zero");
  cvt_short_a: assert property (take_s(OP_CVT) ##0 (a_sht && !a_zero) |=>
    result_o == $past(sht_ext)) else $error("short widening wrong");
  cvt_single_a: assert property (take_s(OP_CVT) ##0 (a_sgl && !a_zero) |=>
    result_o == $past(sgl_ext)) else $error("single widening wrong");
endmodule : fpu_dp_chk

bind float_mul_add_datapath fpu_dp_chk chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_sel_i(op_sel_i),
  .opnd_a_i(opnd_a_i), .opnd_b_i(opnd_b_i), .res_valid_o(res_valid_o), .result_o(result_o),
  .result_sgl_o(result_sgl_o), .ovf_o(ovf_o), .unf_o(unf_o)
);

`default_nettype wire

/* sim/op_source.sv */
// register-file side model that issues datapath requests
`default_nettype none

module op_source
  import fpu_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request toward the datapath
  output var logic op_valid_o,
  output var op_e op_sel_o,
  output var operand_s opnd_a_o,
  output var operand_s opnd_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    op_valid_o = 1'b0;
    op_sel_o = OP_MUL;
    opnd_a_o = '0;
    opnd_b_o = '0;
  end

  // ----------------------------------------
  // request tasks
  // ----------------------------------------
  task automatic drive(input op_e op, input operand_s a, input operand_s b);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_sel_o <= op;
    opnd_a_o <= a;
    opnd_b_o <= b;
  endtask : drive

  // idle operands are not held, so a late capture shows up as garbage
  task automatic idle();
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    opnd_a_o <= ~opnd_a_o;
    opnd_b_o <= ~opnd_b_o;
  endtask : idle
endmodule : op_source

`default_nettype wire

/* sim/tb_top.sv */
// self-checking testbench for the float multiply/add datapath
`default_nettype none

module tb_top
  import fpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk;
  logic rst_b;
  logic op_valid;
  op_e op_sel;
  operand_s opnd_a;
  operand_s opnd_b;
  logic res_valid;
  ext_fp_s result;
  sgl_fp_s result_sgl;
  logic ovf;
  logic unf;
  int num_errors;
  int checks_done;

  op_source src (.clk_i(ref_clk), .op_valid_o(op_valid), .op_sel_o(op_sel),
    .opnd_a_o(opnd_a), .opnd_b_o(opnd_b));

  float_mul_add_datapath uut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .op_valid_i(op_valid),
    .op_sel_i(op_sel), .opnd_a_i(opnd_a), .opnd_b_i(opnd_b), .res_valid_o(res_valid),
    .result_o(result), .result_sgl_o(result_sgl), .ovf_o(ovf), .unf_o(unf));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic operand_s sh(input logic [15:0] v);
    return {FMT_SHORT, 24'h0, v};
  endfunction : sh
  function automatic operand_s sg(input logic [31:0] v);
    return {FMT_SINGLE, 8'h0, v};
  endfunction : sg
  function automatic operand_s ex(input logic [39:0] v);
    return {FMT_EXT, v};
  endfunction : ex

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  // one request, result looked at in the single cycle it is flagged valid
  task automatic run_op(input op_e op, input operand_s a, input operand_s b,
      input logic [39:0] want, input logic [1:0] flags);
    src.drive(op, a, b);
    src.idle();
    #1;
    check("valid", {39'h0, res_valid}, 40'h1);
    check("result", result, want);
    check("flags", {38'h0, ovf, unf}, {38'h0, flags});
  endtask : run_op

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_convert();
    run_op(OP_CVT, sh(16'hF7FF), sh(16'h0), 40'hFF_7FF0_0000, 2'b00);
    check("sgl", {8'h0, result_sgl}, 40'hFF7F_F000);
    run_op(OP_CVT, sh(16'h3A00), sh(16'h0), 40'h03_A000_0000, 2'b00);
    run_op(OP_CVT, sh(16'h8000), sh(16'h0), 40'h80_0000_0000, 2'b00);
    run_op(OP_CVT, sg(32'h0280_0001), sh(16'h0), 40'h02_8000_0100, 2'b00);
  endtask : test_convert

  task automatic test_multiply();
    run_op(OP_MUL, ex(40'h01_4000_00FF), sh(16'h2400), 40'h04_1000_0000, 2'b00);
    run_op(OP_MUL, sg(32'h0080_0000), sg(32'h0080_0000), 40'h02_0000_0000, 2'b00);
    run_op(OP_MUL, ex(40'h0), ex(40'h03_8000_0000), 40'h03_8000_0000, 2'b00);
    run_op(OP_MUL, ex(40'h80_0000_0000), sg(32'h0080_0000), 40'h80_0000_0000, 2'b00);
    run_op(OP_MUL, operand_s'({2'h3, 40'h01_4000_00FF}), sh(16'h2400), 40'h04_1000_0000, 2'b00);
  endtask : test_multiply

  task automatic test_saturate();
    run_op(OP_MUL, ex(40'h7F_4000_0000), ex(40'h7F_4000_0000), 40'h7F_7FFF_FFFF, 2'b10);
    run_op(OP_MUL, ex(40'h7F_4000_0000), ex(40'h7F_8000_0000), 40'h7F_8000_0000, 2'b10);
    run_op(OP_MUL, ex(40'h9C_0000_0000), ex(40'h9C_0000_0000), 40'h80_0000_0000, 2'b01);
    run_op(OP_MUL, ex(40'h7F_4000_0000), ex(40'h00_4000_0000), 40'h7F_7FFF_FFFF, 2'b10);
    run_op(OP_MUL, ex(40'h7F_0000_0000), ex(40'h00_0000_0000), 40'h7F_0000_0000, 2'b00);
    run_op(OP_MUL, ex(40'h81_0000_0000), ex(40'h00_0000_0000), 40'h81_0000_0000, 2'b00);
    run_op(OP_ADD, ex(40'h7F_0000_0000), ex(40'h7F_0000_0000), 40'h7F_7FFF_FFFF, 2'b10);
    run_op(OP_SUB, ex(40'h81_4000_0000), ex(40'h81_0000_0000), 40'h80_0000_0000, 2'b01);
  endtask : test_saturate

  task automatic test_add_sub();
    run_op(OP_ADD, ex(40'h0), ex(40'h0), 40'h01_0000_0000, 2'b00);
    run_op(OP_ADD, ex(40'h01_0000_0000), sh(16'h0000), 40'h01_4000_0000, 2'b00);
    run_op(OP_SUB, ex(40'h00_4000_0000), ex(40'h0), 40'hFF_0000_0000, 2'b00);
    run_op(OP_SUB, ex(40'h00_4000_0000), ex(40'h00_4000_0000), 40'h80_0000_0000, 2'b00);
    run_op(OP_ADD, ex(40'h00_8000_0000), ex(40'h0), 40'hFF_8000_0000, 2'b00);
    run_op(OP_ADD, sg(32'h0280_0001), ex(40'h80_0000_0000), 40'h02_8000_0100, 2'b00);
    run_op(OP_SUB, ex(40'h0), ex(40'h01_0000_0000), 40'hFF_8000_0000, 2'b00);
    run_op(OP_SUB, ex(40'h80_0000_0000), ex(40'h01_4000_0000), 40'h01_C000_0000, 2'b00);
  endtask : test_add_sub

  task automatic test_back_to_back();
    src.drive(OP_ADD, ex(40'h01_0000_0000), sh(16'h0000));
    src.drive(OP_MUL, sg(32'h0080_0000), sg(32'h0080_0000));
    #1;
    check("b2b_add", result, 40'h01_4000_0000);
    src.idle();
    #1;
    check("b2b_mul", result, 40'h02_0000_0000);
    src.idle();
    #1;
    check("b2b_idle", result, 40'h02_0000_0000);
    check("b2b_valid", {39'h0, res_valid}, 40'h0);
  endtask : test_back_to_back

  task automatic test_reset();
    run_op(OP_CVT, ex(40'h05_1234_5678), ex(40'h0), 40'h05_1234_5678, 2'b00);
    check("trunc", {8'h0, result_sgl}, 40'h0512_3456);
    run_op(OP_MUL, ex(40'h7F_4000_0000), ex(40'h7F_4000_0000), 40'h7F_7FFF_FFFF, 2'b10);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check("rst_mid", result, EXT_ZERO);
    check("rst_flags", {37'h0, res_valid, ovf, unf}, 40'h0);
    run_op(OP_ADD, ex(40'h0), ex(40'h0), 40'h01_0000_0000, 2'b00);
  endtask : test_reset

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check("rst_res", result, EXT_ZERO);
    test_convert();
    test_multiply();
    test_saturate();
    test_add_sub();
    test_back_to_back();
    test_reset();
    results();
  end
endmodule : tb_top

`default_nettype wire
